//--- pkg/async_bus_cfg.svh
`ifndef ASYNC_BUS_CFG_SVH
`define ASYNC_BUS_CFG_SVH
// transfer size codes on the size lines
`define SIZE_CODE_BYTE 2'h1
`define SIZE_CODE_WORD 2'h2
`define SIZE_CODE_THREE 2'h3
`define SIZE_CODE_LONG 2'h0
// port acknowledge codes {hi, lo}
`define ACK_CODE_WAIT 2'h3
`define ACK_CODE_PORT8 2'h2
`define ACK_CODE_PORT16 2'h1
// space code values
`define SPACE_TOP_BIT 3'h4
`define SPACE_CONTROL 3'h7
// reset values of the pins
`define ADDR_RESET 20'h00000
`define SPACE_RESET 3'h5
// bus monitor limit in core cycles
`define MONITOR_CYCLES 16'h0040
`endif

//--- pkg/async_bus_pkg.sv
package async_bus_pkg;
  typedef enum logic [1:0] {
    OPSIZE_BYTE,
    OPSIZE_WORD,
    OPSIZE_LONG
  } op_size_t;
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_DATA,
    ST_WAIT,
    ST_LATCH,
    ST_END
  } bus_state_t;
endpackage : async_bus_pkg

//--- rtl/async_bus_master.sv
// Operation
// - size lines show remaining bytes, per word for an odd long
// - top space code bit always high
// - space code driven at start, held
// - address of top byte; upper lines mirror
// - address strobe half clock after start
// - read data captured at cycle end
// - writes drive all sixteen data lines
// - write data half clock after strobe
// - read data strobe with address strobe
// - write data strobe one clock later
// - ack codes: wait, 8-bit, 16-bit, reserved
// - ack ends read or write cycle
// - bus fault terminates with error
// - fault with halt gives error exception
// - internal monitor raises fault on stall
// - autovector ends interrupt acknowledge only
// - assume 16-bit port, largest transfer
// - one aligned word per cycle, msw first
// - odd long split into two words
// - lane routing by size, addr0, port
// - size codes byte 01, word 10
// - direction changes only at cycle start
`include "async_bus_cfg.svh"
`timescale 1ns/1ps
module async_bus_master #(
  parameter logic [15:0] MONITOR_LIMIT = `MONITOR_CYCLES
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // core request side
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_iack_i,
  input wire async_bus_pkg::op_size_t req_size_i,
  input wire logic [19:0] req_addr_i,
  input wire logic [1:0] req_space_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic bus_error_o,
  output logic error_halt_o,
  output logic autovector_o,
  // external bus pins
  output logic [23:0] addr_o,
  output logic [2:0] space_code_lines_o,
  output logic transfer_size_hi_o,
  output logic transfer_size_lo_o,
  output logic read_write_dir_o,
  output logic addr_valid_strobe_n_o,
  output logic data_valid_strobe_n_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic [15:0] data_i,
  input wire logic port_ack_hi_n_i,
  input wire logic port_ack_lo_n_i,
  input wire logic bus_fault_in_n_i,
  input wire logic halt_n_i,
  input wire logic auto_vector_request_n_i
);
  import async_bus_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [4:0] sync1_reg;
  logic [4:0] sync1_next;
  logic [4:0] sync2_reg;
  logic [4:0] sync2_next;
  logic [15:0] din1_reg;
  logic [15:0] din1_next;
  logic [15:0] din2_reg;
  logic [15:0] din2_next;

  always_comb begin
    sync1_next = {port_ack_hi_n_i, port_ack_lo_n_i, bus_fault_in_n_i, halt_n_i, auto_vector_request_n_i};
    sync2_next = sync1_reg;
    din1_next = data_i;
    din2_next = din1_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
      din1_reg <= 16'h0000;
      din2_reg <= 16'h0000;
    end else if (ce_i) begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      din1_reg <= din1_next;
      din2_reg <= din2_next;
    end
  end

  logic [1:0] ack_code;
  logic fault_pin;
  logic halt_pin;
  logic auto_vector_request_pin;
  assign ack_code = sync2_reg[4:3];
  assign fault_pin = ~sync2_reg[2];
  assign halt_pin = ~sync2_reg[1];
  assign auto_vector_request_pin = ~sync2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // bytes moved this cycle; a 16-bit port never moves more than one aligned word
  function automatic logic [2:0] moved_bytes(input logic [2:0] rem, input logic a0, input logic p8);
    if (p8 || a0 || rem == 3'h1) begin
      moved_bytes = 3'h1;
    end else begin
      moved_bytes = 3'h2;
    end
  endfunction : moved_bytes

  function automatic logic [1:0] size_code(input logic [2:0] rem);
    size_code = (rem == 3'h4) ? `SIZE_CODE_LONG : rem[1:0];
  endfunction : size_code

  ////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer; each state is half a bus clock
  bus_state_t state_reg, state_next;
  logic [19:0] addr_reg, addr_next;
  logic [2:0] rem_reg, rem_next;
  logic pend_reg, pend_next;
  logic [31:0] wbuf_reg, wbuf_next;
  logic [31:0] rbuf_reg, rbuf_next;
  logic write_reg, write_next;
  logic iack_reg, iack_next;
  logic [2:0] fc_reg, fc_next;
  logic [1:0] siz_reg, siz_next;
  logic rw_reg, rw_next;
  logic as_n_reg, as_n_next;
  logic ds_n_reg, ds_n_next;
  logic [15:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic port8_reg, port8_next;
  logic term_reg, term_next;
  logic [15:0] mon_reg, mon_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic errh_reg, errh_next;
  logic auto_vector_request_reg, auto_vector_request_next;
  logic [2:0] nbytes;
  logic [7:0] op_top;
  logic [7:0] op_next;
  logic [7:0] rd_byte;

  assign nbytes = moved_bytes(rem_reg, addr_reg[0], port8_reg);
  assign op_top = wbuf_reg[31:24];
  assign op_next = wbuf_reg[23:16];
  // 8-bit ports and even 16-bit bytes live on the upper lane
  assign rd_byte = (port8_reg || !addr_reg[0]) ? din2_reg[15:8] : din2_reg[7:0];

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    rem_next = rem_reg;
    pend_next = pend_reg;
    wbuf_next = wbuf_reg;
    rbuf_next = rbuf_reg;
    write_next = write_reg;
    iack_next = iack_reg;
    fc_next = fc_reg;
    siz_next = siz_reg;
    rw_next = rw_reg;
    as_n_next = as_n_reg;
    ds_n_next = ds_n_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    port8_next = port8_reg;
    term_next = term_reg;
    mon_next = mon_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    errh_next = 1'b0;
    auto_vector_request_next = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (req_valid_i && ready_reg) begin
          ready_next = 1'b0;
          write_next = req_write_i;
          iack_next = req_iack_i;
          addr_next = req_addr_i;
          fc_next = `SPACE_TOP_BIT | {1'b0, req_space_i};
          rbuf_next = 32'h00000000;
          pend_next = 1'b0;
          unique case (req_size_i)
            OPSIZE_BYTE: begin
              rem_next = 3'h1;
              wbuf_next = {req_wdata_i[7:0], 24'h000000};
            end
            OPSIZE_WORD: begin
              rem_next = 3'h2;
              wbuf_next = {req_wdata_i[15:0], 16'h0000};
            end
            OPSIZE_LONG: begin
              rem_next = req_addr_i[0] ? 3'h2 : 3'h4;
              pend_next = req_addr_i[0];
              wbuf_next = req_wdata_i;
            end
          endcase
          siz_next = size_code(rem_next);
          rw_next = !req_write_i;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // assume a 16-bit port until the ack says otherwise
        port8_next = 1'b0;
        term_next = 1'b0;
        mon_next = 16'h0000;
        as_n_next = 1'b0;
        ds_n_next = write_reg;
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        if (write_reg) begin
          doe_next = 1'b1;
          dout_next = (!addr_reg[0] && rem_reg != 3'h1) ? {op_top, op_next} : {op_top, op_top};
        end
        state_next = ST_DATA;
      end
      ST_DATA: begin
        ds_n_next = 1'b0;
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        mon_next = mon_reg + 16'h0001;
        // fault from the pin or from the stall monitor outranks any ack
        if (fault_pin || mon_reg >= MONITOR_LIMIT) begin
          err_next = 1'b1;
          errh_next = halt_pin;
          term_next = 1'b1;
          state_next = ST_END;
        end else if (iack_reg && auto_vector_request_pin) begin
          auto_vector_request_next = 1'b1;
          term_next = 1'b1;
          state_next = ST_END;
        end else if (ack_code == `ACK_CODE_PORT8 || ack_code == `ACK_CODE_PORT16) begin
          port8_next = (ack_code == `ACK_CODE_PORT8);
          state_next = ST_LATCH;
        end
        // wait code and the reserved code just stretch the cycle
      end
      ST_LATCH: begin
        // this edge stands in for the last falling edge of the cycle
        if (!write_reg) begin
          rbuf_next = (nbytes == 3'h2) ? {rbuf_reg[15:0], din2_reg} : {rbuf_reg[23:0], rd_byte};
        end
        state_next = ST_END;
      end
      ST_END: begin
        as_n_next = 1'b1;
        ds_n_next = 1'b1;
        doe_next = 1'b0;
        if (term_reg) begin
          rem_next = 3'h0;
          pend_next = 1'b0;
        end else begin
          rem_next = rem_reg - nbytes;
          addr_next = addr_reg + {17'h00000, nbytes};
          wbuf_next = (nbytes == 3'h2) ? {wbuf_reg[15:0], 16'h0000} : {wbuf_reg[23:0], 8'h00};
        end
        if (rem_next == 3'h0 && pend_next) begin
          rem_next = 3'h2;
          pend_next = 1'b0;
        end
        if (rem_next == 3'h0) begin
          done_next = 1'b1;
          rdata_next = rbuf_next;
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          siz_next = size_code(rem_next);
          state_next = ST_ADDR;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      addr_reg <= `ADDR_RESET;
      rem_reg <= 3'h0;
      pend_reg <= 1'b0;
      wbuf_reg <= 32'h00000000;
      rbuf_reg <= 32'h00000000;
      write_reg <= 1'b0;
      iack_reg <= 1'b0;
      fc_reg <= `SPACE_RESET;
      siz_reg <= `SIZE_CODE_BYTE;
      rw_reg <= 1'b1;
      as_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
      dout_reg <= 16'h0000;
      doe_reg <= 1'b0;
      port8_reg <= 1'b0;
      term_reg <= 1'b0;
      mon_reg <= 16'h0000;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
      errh_reg <= 1'b0;
      auto_vector_request_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      rem_reg <= rem_next;
      pend_reg <= pend_next;
      wbuf_reg <= wbuf_next;
      rbuf_reg <= rbuf_next;
      write_reg <= write_next;
      iack_reg <= iack_next;
      fc_reg <= fc_next;
      siz_reg <= siz_next;
      rw_reg <= rw_next;
      as_n_reg <= as_n_next;
      ds_n_reg <= ds_n_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      port8_reg <= port8_next;
      term_reg <= term_next;
      mon_reg <= mon_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      // flags stand through the done pulse, clear the cycle after
      err_reg <= err_next | (err_reg & ~done_reg);
      errh_reg <= errh_next | (errh_reg & ~done_reg);
      auto_vector_request_reg <= auto_vector_request_next | (auto_vector_request_reg & ~done_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from registers
  assign req_ready_o = ready_reg;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign bus_error_o = err_reg;
  assign error_halt_o = errh_reg;
  assign autovector_o = auto_vector_request_reg;
  assign addr_o = {{4{addr_reg[19]}}, addr_reg};
  assign space_code_lines_o = fc_reg;
  assign transfer_size_hi_o = siz_reg[1];
  assign transfer_size_lo_o = siz_reg[0];
  assign read_write_dir_o = rw_reg;
  assign addr_valid_strobe_n_o = as_n_reg;
  assign data_valid_strobe_n_o = ds_n_reg;
  assign data_o = dout_reg;
  assign data_oe_o = doe_reg;
endmodule : async_bus_master

//--- dv/async_bus_master_sva.sv
`timescale 1ns/1ps
module async_bus_master_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // bus pins
  input wire logic [23:0] addr_o,
  input wire logic [2:0] space_code_lines_o,
  input wire logic transfer_size_hi_o,
  input wire logic transfer_size_lo_o,
  input wire logic read_write_dir_o,
  input wire logic addr_valid_strobe_n_o,
  input wire logic data_valid_strobe_n_o,
  input wire logic [15:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  chk_space_top: assert property (!addr_valid_strobe_n_o |-> space_code_lines_o[2] && space_code_lines_o != 3'h4)
    else $error("space code out of range");
  chk_cycle_hold: assert property (!addr_valid_strobe_n_o && $past(!addr_valid_strobe_n_o) |->
    $stable({addr_o, space_code_lines_o, transfer_size_hi_o, transfer_size_lo_o, read_write_dir_o}))
    else $error("cycle control moved under strobe");
  chk_addr_mirror: assert property (addr_o[23:20] == {4{addr_o[19]}})
    else $error("upper address lines differ");
  chk_addr_early: assert property ($fell(addr_valid_strobe_n_o) |-> $stable(addr_o) && $stable(space_code_lines_o))
    else $error("address not set before strobe");
  chk_write_drive: assert property (!read_write_dir_o && !data_valid_strobe_n_o |-> data_oe_o)
    else $error("write data lines not driven");
  chk_write_data: assert property ($fell(addr_valid_strobe_n_o) && !read_write_dir_o |-> !data_oe_o ##1 data_oe_o)
    else $error("write data timing");
  chk_read_ds: assert property ($fell(addr_valid_strobe_n_o) && read_write_dir_o |-> !data_valid_strobe_n_o)
    else $error("read data strobe late");
  chk_write_ds: assert property ($fell(addr_valid_strobe_n_o) && !read_write_dir_o |->
    data_valid_strobe_n_o [*2] ##1 !data_valid_strobe_n_o)
    else $error("write data strobe timing");
  chk_dir_start: assert property ($changed(read_write_dir_o) |-> addr_valid_strobe_n_o)
    else $error("direction changed in cycle");
  chk_wait_hold: assert property (data_oe_o && $past(data_oe_o) && !addr_valid_strobe_n_o |-> $stable(data_o))
    else $error("write data moved in cycle");
endmodule : async_bus_master_sva

//--- dv/ext_port_model.sv
`timescale 1ns/1ps
`include "async_bus_cfg.svh"
module ext_port_model (
  // clock and port setup
  input wire logic core_clk_i,
  input wire logic port8_i,
  input wire logic [7:0] wait_i,
  // bus from master
  input wire logic [23:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic dir_i,
  input wire logic as_n_i,
  input wire logic ds_n_i,
  input wire logic [15:0] wdata_i,
  // answers
  output logic [15:0] rdata_o = 16'h0000,
  output logic ack_hi_n_o = 1'b1,
  output logic ack_lo_n_o = 1'b1
);
  logic [7:0] mem [0:255];
  logic [7:0] cnt = 8'h00;
  logic acked = 1'b0;
  logic [7:0] a;
  assign a = addr_i[7:0];
  // wait_i of ff never answers, so the master must end the cycle itself
  always @(posedge core_clk_i) begin
    rdata_o <= acked ? rdata_o : ~rdata_o;
    if (as_n_i) begin
      cnt <= 8'h00;
      acked <= 1'b0;
      {ack_hi_n_o, ack_lo_n_o} <= `ACK_CODE_WAIT;
    end else if (!ds_n_i && !acked) begin
      cnt <= cnt + 8'h01;
      if (cnt >= wait_i && wait_i != 8'hff) begin
        acked <= 1'b1;
        {ack_hi_n_o, ack_lo_n_o} <= port8_i ? `ACK_CODE_PORT8 : `ACK_CODE_PORT16;
        if (dir_i) begin
          rdata_o <= port8_i ? {mem[a], ~mem[a]} : {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
        end else if (port8_i) begin
          mem[a] <= wdata_i[15:8];
        end else if (a[0]) begin
          mem[a] <= wdata_i[7:0];
        end else begin
          mem[a] <= wdata_i[15:8];
          if (size_i != `SIZE_CODE_BYTE) begin
            mem[a + 8'h01] <= wdata_i[7:0];
          end
        end
      end
    end
  end
endmodule : ext_port_model

//--- dv/test_async_bus_master.sv
`timescale 1ns/1ps
module test_async_bus_master;
  import async_bus_pkg::*;
  // design and port model inputs
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic req_iack_i = 1'b0;
  op_size_t req_size_i = OPSIZE_BYTE;
  logic [19:0] req_addr_i = 20'h00000;
  logic [1:0] req_space_i = 2'h1;
  logic [31:0] req_wdata_i = 32'h00000000;
  logic bus_fault_in_n_i = 1'b1;
  logic halt_n_i = 1'b1;
  logic auto_vector_request_n_i = 1'b1;
  logic port8 = 1'b0;
  logic [7:0] wait_len = 8'h02;
  // outputs and wires
  logic req_ready_o, done_o, bus_error_o, error_halt_o, autovector_o;
  logic transfer_size_hi_o, transfer_size_lo_o, read_write_dir_o, addr_valid_strobe_n_o;
  logic data_valid_strobe_n_o, data_oe_o, port_ack_hi_n_i, port_ack_lo_n_i;
  logic [31:0] rdata_o;
  logic [23:0] addr_o;
  logic [2:0] space_code_lines_o, flags;
  logic [15:0] data_o, data_i, port_data;
  int errors = 0;
  int n_checks = 0;
  int n_as = 0;
  always #5 core_clk_i = ~core_clk_i;
  always @(negedge addr_valid_strobe_n_o) n_as++;
  assign data_i = data_oe_o ? data_o : port_data;
  async_bus_master #(.MONITOR_LIMIT(16'h0008)) async_bus_master_inst (.*);
  ext_port_model ext_port_model_inst (.core_clk_i, .port8_i(port8), .wait_i(wait_len), .addr_i(addr_o),
    .size_i({transfer_size_hi_o, transfer_size_lo_o}), .dir_i(read_write_dir_o), .as_n_i(addr_valid_strobe_n_o),
    .ds_n_i(data_valid_strobe_n_o), .wdata_i(data_i), .rdata_o(port_data), .ack_hi_n_o(port_ack_hi_n_i),
    .ack_lo_n_o(port_ack_lo_n_i));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic wr, input logic [1:0] sp, input op_size_t sz, input logic [19:0] ad,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_space_i <= sp;
    req_size_i <= sz;
    req_addr_i <= ad;
    req_wdata_i <= wd;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    #1;
    while (done_o !== 1'b1 && n < 3000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    flags = {bus_error_o, error_halt_o, autovector_o};
    chk({31'h0, done_o}, 32'h1);
  endtask : op
  // write then read back, counting bus cycles of the read
  task automatic rw(input logic [1:0] sp, input op_size_t sz, input logic [19:0] ad, input logic [31:0] wd,
      input int ncyc);
    int n0;
    op(1'b1, sp, sz, ad, wd);
    n0 = n_as;
    op(1'b0, sp, sz, ad, 32'h0);
    chk(rdata_o, wd);
    chk(32'(n_as - n0), 32'(ncyc));
  endtask : rw
  ////////////////////////////////////////
  task automatic t_long16();
    port8 <= 1'b0;
    rw(2'h1, OPSIZE_LONG, 20'h00010, 32'hdeadbeef, 2);
    chk({24'h0, ext_port_model_inst.mem[8'h10]}, 32'hde);
    rw(2'h1, OPSIZE_LONG, 20'h00031, 32'h89abcdef, 4);
  endtask : t_long16
  task automatic t_port8();
    port8 <= 1'b1;
    rw(2'h2, OPSIZE_WORD, 20'h00023, 32'h00001234, 2);
    chk({24'h0, ext_port_model_inst.mem[8'h23]}, 32'h12);
    rw(2'h2, OPSIZE_LONG, 20'h00044, 32'h01020304, 4);
    port8 <= 1'b0;
  endtask : t_port8
  task automatic t_fault();
    @(posedge core_clk_i);
    wait_len <= 8'hff;
    bus_fault_in_n_i <= 1'b0;
    halt_n_i <= 1'b0;
    op(1'b0, 2'h1, OPSIZE_WORD, 20'h00050, 32'h0);
    chk({29'h0, flags}, 32'h6);
    @(posedge core_clk_i);
    bus_fault_in_n_i <= 1'b1;
    halt_n_i <= 1'b1;
    op(1'b0, 2'h1, OPSIZE_WORD, 20'h00050, 32'h0);
    chk({29'h0, flags}, 32'h4);
  endtask : t_fault
  task automatic t_auto_vector_request();
    @(posedge core_clk_i);
    auto_vector_request_n_i <= 1'b0;
    req_iack_i <= 1'b1;
    op(1'b0, 2'h3, OPSIZE_BYTE, 20'h00007, 32'h0);
    chk({29'h0, flags}, 32'h1);
    @(posedge core_clk_i);
    req_iack_i <= 1'b0;
    wait_len <= 8'h02;
    op(1'b0, 2'h1, OPSIZE_BYTE, 20'h00010, 32'h0);
    chk({29'h0, flags}, 32'h0);
    chk(rdata_o, 32'h000000de);
  endtask : t_auto_vector_request
  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_long16();
    t_port8();
    t_fault();
    t_auto_vector_request();
    print_verdict();
  end
  // each operation takes well under 300 cycles
  initial begin
    #300000;
    errors++;
    print_verdict();
  end
endmodule : test_async_bus_master
bind async_bus_master async_bus_master_sva async_bus_master_sva_inst (.*);
